// ### rtl/cmd_src_pkg.sv
/*
 * Constants and types for the run command source selector.
 * Assumes a 40 MHz control clock; all users import the whole package.
 */
package cmd_src_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int NUM_TERMS = 11;
	localparam int FUNC_W = 6;
	localparam logic [5:0] FUNC_MAX = 6'h33;
	localparam logic [5:0] FUNC_FWD_RUN = 6'h01;
	localparam logic [5:0] FUNC_REV_DIR = 6'h02;

	// Command source selector codes
	localparam logic [2:0] SRC_KEYPAD = 3'h0;
	localparam logic [2:0] SRC_TWO_WIRE = 3'h1;
	localparam logic [2:0] SRC_RUN_DIR = 3'h2;
	localparam logic [2:0] SRC_SERIAL = 3'h3;
	localparam logic [2:0] SRC_FIELDBUS = 3'h4;
	localparam logic [2:0] SRC_PLC = 3'h5;
	localparam logic [2:0] SRC_RESET = SRC_TWO_WIRE;

	// Run-on delay, in hundredths of a second
	localparam logic [13:0] DELAY_MAX_CS = 14'h2710;
	localparam logic [13:0] DELAY_RESET_CS = 14'h0064;
	localparam int unsigned CS_TIME_S_DIV = 100;
	localparam int unsigned CYC_PER_CS = CLK_HZ / CS_TIME_S_DIV;
	localparam logic [18:0] CYC_PER_CS_M1 = 19'(CYC_PER_CS - 1);

	// Serial settings
	localparam logic [7:0] STATION_MIN = 8'h01;
	localparam logic [7:0] STATION_MAX = 8'hfa;
	localparam logic [7:0] STATION_RESET = 8'h01;
	localparam logic [1:0] PROTO_RESET = 2'h0; // Modbus RTU
	localparam logic [2:0] RATE_RESET = 3'h3; // 9600 bps
	localparam logic [2:0] RATE_MAX = 3'h5; // 38400 bps
	localparam logic [1:0] FORMAT_RESET = 2'h0; // 8 data, no parity, 1 stop
	localparam logic [1:0] FORMAT_MAX = 2'h3;

	typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} run_state_t;
endpackage : cmd_src_pkg

// ### rtl/run_delay_if.sv
/*
 * Carries run request and delay handshake between selector and delay timer.
 * Assumes both ends share the selector's clock.
 */
`timescale 1ns/100ps
interface run_delay_if;
	logic start;
	logic [13:0] delay_cs;
	logic done;
	modport ctrl (output start, output delay_cs, input done);
	modport timer (input start, input delay_cs, output done);
endinterface : run_delay_if

// ### rtl/run_delay_timer.sv
/*
 * Run-on delay timer counting hundredths of a second.
 * Assumes start is held high for the whole wait; dropping it restarts the count.
 */
`timescale 1ns/100ps
module run_delay_timer
	import cmd_src_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	run_delay_if.timer dly
);
	import cmd_src_pkg::*;

	logic [18:0] tick_r;
	logic [13:0] cs_r;
	logic done_r;
	wire tick_wrap = (tick_r == CYC_PER_CS_M1);
	wire at_target = (cs_r >= dly.delay_cs);

	// Prescaler and hundredths counter, both cleared while idle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_r <= 19'h0;
			cs_r <= 14'h0;
			done_r <= 1'b0;
		end else if (!dly.start) begin
			tick_r <= 19'h0;
			cs_r <= 14'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= at_target;
			tick_r <= tick_wrap ? 19'h0 : tick_r + 19'h1;
			if (tick_wrap && !at_target)
				cs_r <= cs_r + 14'h1;
		end
	end
	assign dly.done = done_r;

	run_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!dly.start |=> !dly.done) else $error("delay done without start");
endmodule : run_delay_timer

// ### rtl/run_command_source_select.sv
/*
 * Run command source selector: keypad, terminal modes, serial, fieldbus, PLC.
 * Assumes all inputs synchronous to i_clk; settings come from parameter storage.
 */
`timescale 1ns/100ps
// Operation
// - With selector 0 the forward key runs forward, reverse key runs reverse, stop key stops.
// - Selector 1 is two-wire terminal mode with a forward input and a reverse input.
// - Each of eleven terminals takes a function code 0 to 51; 1 is forward/run, 2 is reverse/direction.
// - In two-wire mode forward alone runs forward and reverse alone runs reverse.
// - In two-wire mode both inputs on or both off means stop.
// - Selector 2 uses the run input as run request and the direction input as reverse when on.
// - In terminal modes a run request waits a run-on delay of 0.00 to 100.00 s, default 1.00.
// - Selector 3 obeys run commands from the serial port.
// - The serial port answers only its station id, 1 to 250, default 1.
// - Serial protocol defaults to 0, Modbus RTU.
// - Serial bit rate is selectable 1200 to 38400, default 9600.
// - Serial character format defaults to 8 data bits, no parity, one stop bit.
// - Selector 4 selects the fieldbus and 5 selects the PLC option.
module run_command_source_select
	import cmd_src_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cfg_we,
	input wire logic [2:0] i_command_source_select,
	input wire logic [13:0] i_run_delay_cs,
	input wire logic [7:0] i_serial_station_id,
	input wire logic [1:0] i_serial_protocol_select,
	input wire logic [2:0] i_serial_bit_rate,
	input wire logic [1:0] i_serial_char_format,
	input wire logic i_func_we,
	input wire logic [3:0] i_func_idx,
	input wire logic [cmd_src_pkg::FUNC_W-1:0] i_func_code,
	input wire logic [cmd_src_pkg::NUM_TERMS-1:0] i_multi_function_terminal,
	input wire logic i_key_fwd,
	input wire logic i_key_rev,
	input wire logic i_key_stop,
	input wire logic [7:0] i_serial_addr,
	input wire logic i_serial_cmd_valid,
	input wire logic i_serial_run,
	input wire logic i_serial_rev,
	input wire logic i_fieldbus_run,
	input wire logic i_fieldbus_rev,
	input wire logic i_plc_run,
	input wire logic i_plc_rev,
	output logic o_run,
	output logic o_reverse,
	output logic o_run_pending,
	output logic o_serial_addr_match,
	output logic [2:0] o_command_source_select,
	output logic [7:0] o_serial_station_id,
	output logic [1:0] o_serial_protocol_select,
	output logic [2:0] o_serial_bit_rate,
	output logic [1:0] o_serial_char_format,
	output logic o_cfg_error
);
	import cmd_src_pkg::*;

	logic rst_s1_r, rst_s2_r;
	logic rst_n;
	logic [2:0] src_r;
	logic [13:0] delay_r;
	logic [7:0] station_r;
	logic [1:0] proto_r;
	logic [2:0] rate_r;
	logic [1:0] format_r;
	logic [FUNC_W-1:0] func_r [NUM_TERMS];
	logic [NUM_TERMS-1:0] is_fwd, is_rev;
	logic key_run_r, key_rev_r;
	logic ser_run_r, ser_rev_r;
	logic run_r, rev_r, pend_r, match_r, err_r;
	run_state_t state_r, state_nxt;
	run_delay_if dly ();

	// Reset release through two flops so all logic leaves reset together
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_s2_r;

	// Out-of-range settings are refused and flagged instead of clamped
	wire src_ok = (i_command_source_select <= SRC_PLC);
	wire delay_ok = (i_run_delay_cs <= DELAY_MAX_CS);
	wire station_ok = (i_serial_station_id >= STATION_MIN) && (i_serial_station_id <= STATION_MAX);
	wire rate_ok = (i_serial_bit_rate <= RATE_MAX);
	wire format_ok = (i_serial_char_format <= FORMAT_MAX);
	wire cfg_ok = src_ok && delay_ok && station_ok && rate_ok && format_ok;
	wire func_ok = (i_func_code <= FUNC_MAX) && (i_func_idx < 4'(NUM_TERMS));

	// Setting storage
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_r <= SRC_RESET;
			delay_r <= DELAY_RESET_CS;
			station_r <= STATION_RESET;
			proto_r <= PROTO_RESET;
			rate_r <= RATE_RESET;
			format_r <= FORMAT_RESET;
			err_r <= 1'b0;
		end else begin
			if (i_cfg_we && cfg_ok) begin
				src_r <= i_command_source_select;
				delay_r <= i_run_delay_cs;
				station_r <= i_serial_station_id;
				proto_r <= i_serial_protocol_select;
				rate_r <= i_serial_bit_rate;
				format_r <= i_serial_char_format;
			end
			err_r <= (i_cfg_we && !cfg_ok) || (i_func_we && !func_ok);
		end
	end

	// Terminal function table, one entry per terminal
	genvar g;
	generate
		for (g = 0; g < NUM_TERMS; g++) begin : g_term
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n)
					func_r[g] <= '0;
				else if (i_func_we && func_ok && i_func_idx == 4'(g))
					func_r[g] <= i_func_code;
			end
			assign is_fwd[g] = (func_r[g] == FUNC_FWD_RUN);
			assign is_rev[g] = (func_r[g] == FUNC_REV_DIR);
		end
	endgenerate

	// Any terminal carrying the forward or reverse function asserts that function
	wire term_fwd = |(is_fwd & i_multi_function_terminal);
	wire term_rev = |(is_rev & i_multi_function_terminal);

	// Keypad latch: keys are momentary, stop wins over a start key
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_run_r <= 1'b0;
			key_rev_r <= 1'b0;
		end else if (src_r != SRC_KEYPAD || i_key_stop) begin
			key_run_r <= 1'b0;
		end else if (i_key_fwd && !i_key_rev) begin
			key_run_r <= 1'b1;
			key_rev_r <= 1'b0;
		end else if (i_key_rev && !i_key_fwd) begin
			key_run_r <= 1'b1;
			key_rev_r <= 1'b1;
		end
	end

	// Serial command latch; frames for other stations are dropped
	wire addr_hit = (i_serial_addr == station_r);
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_run_r <= 1'b0;
			ser_rev_r <= 1'b0;
			match_r <= 1'b0;
		end else begin
			match_r <= i_serial_cmd_valid && addr_hit;
			if (src_r != SRC_SERIAL)
				ser_run_r <= 1'b0;
			else if (i_serial_cmd_valid && addr_hit) begin
				ser_run_r <= i_serial_run;
				ser_rev_r <= i_serial_rev;
			end
		end
	end

	// Per-source request decode; only the selected source reaches the run state
	wire two_run = term_fwd ^ term_rev;
	wire two_rev = term_rev && !term_fwd;
	wire rd_run = term_fwd;
	wire rd_rev = term_rev;
	wire term_mode = (src_r == SRC_TWO_WIRE) || (src_r == SRC_RUN_DIR);
	logic req_run, req_rev;
	always_comb begin
		req_run = 1'b0;
		req_rev = 1'b0;
		case (src_r)
			SRC_KEYPAD: begin
				req_run = key_run_r;
				req_rev = key_rev_r;
			end
			SRC_TWO_WIRE: begin
				req_run = two_run;
				req_rev = two_rev;
			end
			SRC_RUN_DIR: begin
				req_run = rd_run;
				req_rev = rd_rev;
			end
			SRC_SERIAL: begin
				req_run = ser_run_r;
				req_rev = ser_rev_r;
			end
			SRC_FIELDBUS: begin
				req_run = i_fieldbus_run;
				req_rev = i_fieldbus_rev;
			end
			SRC_PLC: begin
				req_run = i_plc_run;
				req_rev = i_plc_rev;
			end
			default: begin
				req_run = 1'b0;
				req_rev = 1'b0;
			end
		endcase
	end

	// Run state: terminal modes pass through the run-on delay first
	assign dly.start = (state_r == ST_WAIT) && req_run;
	assign dly.delay_cs = delay_r;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_STOP: begin
				if (req_run)
					state_nxt = term_mode ? ST_WAIT : ST_RUN;
			end
			ST_WAIT: begin
				if (!req_run)
					state_nxt = ST_STOP;
				// A switch away from the terminals must not keep the terminal delay
				else if (dly.done || !term_mode)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!req_run)
					state_nxt = ST_STOP;
			end
			default: state_nxt = ST_STOP;
		endcase
	end

	run_delay_timer u_timer (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.dly(dly.timer)
	);

	// State and registered outputs
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_STOP;
			run_r <= 1'b0;
			rev_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			run_r <= (state_nxt == ST_RUN);
			pend_r <= (state_nxt == ST_WAIT);
			if (req_run)
				rev_r <= req_rev;
		end
	end

	assign o_run = run_r;
	assign o_reverse = rev_r;
	assign o_run_pending = pend_r;
	assign o_serial_addr_match = match_r;
	assign o_command_source_select = src_r;
	assign o_serial_station_id = station_r;
	assign o_serial_protocol_select = proto_r;
	assign o_serial_bit_rate = rate_r;
	assign o_serial_char_format = format_r;
	assign o_cfg_error = err_r;

	two_wire_stop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_TWO_WIRE && term_fwd == term_rev && state_r == ST_RUN) |=> !run_r)
		else $error("two-wire both equal did not stop");
	keypad_stop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_KEYPAD && i_key_stop) |=> ##1 !run_r)
		else $error("stop key ignored");
	term_delay_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(term_mode && state_r == ST_STOP && req_run && delay_r != 14'h0) |=> !run_r)
		else $error("terminal run skipped delay");
	serial_addr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_serial_cmd_valid && !addr_hit && src_r == SRC_SERIAL) |=> $stable(ser_run_r))
		else $error("foreign station obeyed");
	serial_run_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_SERIAL && $stable(src_r) && i_serial_cmd_valid && addr_hit && i_serial_run
		&& state_r == ST_STOP) |=> ##1 run_r)
		else $error("serial run not obeyed");
	other_src_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_PLC && !i_plc_run) |=> !run_r)
		else $error("non-selected source ran");
	fieldbus_run_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_FIELDBUS && i_fieldbus_run) |=> run_r && (rev_r == $past(i_fieldbus_rev)))
		else $error("fieldbus run not followed");
	station_range_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		station_r >= STATION_MIN && station_r <= STATION_MAX && rate_r <= RATE_MAX)
		else $error("serial setting out of range");
	func_range_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_func_we && i_func_code > FUNC_MAX) |=> o_cfg_error)
		else $error("bad function code not flagged");
	run_dir_a: assert property (@(posedge i_clk) disable iff (!rst_n)
		(src_r == SRC_RUN_DIR && term_fwd) |=> rev_r == $past(term_rev))
		else $error("direction not taken from reverse input");
endmodule : run_command_source_select

// ### verification/cmd_far_side.sv
/*
 * Far-side model: keypad, input terminals, serial host, fieldbus and PLC levels.
 * Assumes one bench process calls its tasks, just after a rising clock edge.
 */
`timescale 1ns/100ps
module cmd_far_side (
	input wire logic i_clk,
	output logic [10:0] o_terms,
	output logic [2:0] o_keys,
	output logic [1:0] o_fieldbus,
	output logic [1:0] o_plc,
	output logic [7:0] o_addr,
	output logic o_valid,
	output logic o_srun,
	output logic o_srev
);
	// Everything idle at time zero
	initial begin
		o_terms = '0;
		o_keys = '0;
		o_fieldbus = '0;
		o_plc = '0;
		o_addr = 8'hff;
		o_valid = 1'b0;
		o_srun = 1'b0;
		o_srev = 1'b0;
	end

	// Levels; keys are {stop, rev, fwd}, fieldbus and plc are {run, rev}
	task automatic set_lv(input logic [10:0] t, input logic [2:0] k, input logic [1:0] f, input logic [1:0] p);
		o_terms = t;
		o_keys = k;
		o_fieldbus = f;
		o_plc = p;
	endtask : set_lv

	// One decoded frame; the same rate and format are assumed at both ends
	task automatic send_frame(input logic [7:0] a, input logic r, input logic d);
		o_addr = a;
		o_srun = r;
		o_srev = d;
		o_valid = 1'b1;
		@(posedge i_clk);
		#2;
		o_valid = 1'b0;
		// Released fields show the inverse, so stale values cannot pass
		o_addr = ~a;
		o_srun = ~r;
		o_srev = ~d;
	endtask : send_frame
endmodule : cmd_far_side

// ### verification/test_run_command_source_select.sv
/*
 * Self-checking bench for the run command source selector.
 * Assumes the far-side model drives every source input of the selector.
 */
`timescale 1ns/100ps
module test_run_command_source_select;
	import cmd_src_pkg::*;
	logic i_clk, i_rst_n, we, fwe, run, rev, pend, match, err;
	logic [2:0] sel, rate, o_sel, o_rate;
	logic [13:0] dly;
	logic [7:0] st, o_st, saddr;
	logic [1:0] o_proto, o_fmt, fb, plc, proto, fmt;
	logic [3:0] fidx;
	logic [5:0] fcode;
	logic [10:0] terms;
	logic [2:0] keys;
	logic sval, srun, srev;
	int n_mismatch = 0;
	int comparisons = 0;

	run_command_source_select dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_we(we),
		.i_command_source_select(sel), .i_run_delay_cs(dly), .i_serial_station_id(st),
		.i_serial_protocol_select(proto), .i_serial_bit_rate(rate), .i_serial_char_format(fmt),
		.i_func_we(fwe), .i_func_idx(fidx), .i_func_code(fcode), .i_multi_function_terminal(terms),
		.i_key_fwd(keys[0]), .i_key_rev(keys[1]), .i_key_stop(keys[2]), .i_serial_addr(saddr),
		.i_serial_cmd_valid(sval), .i_serial_run(srun), .i_serial_rev(srev), .i_fieldbus_run(fb[1]),
		.i_fieldbus_rev(fb[0]), .i_plc_run(plc[1]), .i_plc_rev(plc[0]), .o_run(run), .o_reverse(rev),
		.o_run_pending(pend), .o_serial_addr_match(match), .o_command_source_select(o_sel),
		.o_serial_station_id(o_st), .o_serial_protocol_select(o_proto), .o_serial_bit_rate(o_rate),
		.o_serial_char_format(o_fmt), .o_cfg_error(err));
	cmd_far_side far (.i_clk(i_clk), .o_terms(terms), .o_keys(keys), .o_fieldbus(fb), .o_plc(plc),
		.o_addr(saddr), .o_valid(sval), .o_srun(srun), .o_srev(srev));

	// 40 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask : tick

	task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Idle cycle first, so the write strobe is never raised in the step that lowered it
	task automatic cfg(input logic [2:0] s, input logic [13:0] d, input logic [7:0] id, input logic [2:0] r,
			input logic bad);
		tick(1);
		sel = s;
		dly = d;
		st = id;
		rate = r;
		we = 1'b1;
		tick(1);
		we = 1'b0;
		chk("cfg_error", bad, err);
	endtask : cfg

	task automatic fw(input logic [3:0] i, input logic [5:0] c, input logic bad);
		tick(1);
		fidx = i;
		fcode = c;
		fwe = 1'b1;
		tick(1);
		fwe = 1'b0;
		chk("func_error", bad, err);
	endtask : fw

	// Bounded wait: with zero delay every source settles within a few cycles
	// One edge first, so a direction change on a running drive has landed
	task automatic wait_run(input logic r, input logic d);
		tick(1);
		for (int i = 0; i < 8 && run !== r; i++) tick(1);
		chk("run", r, run);
		if (r) chk("reverse", d, rev);
	endtask : wait_run

	// Fwd on terminal 3, rev on terminal 10, unassigned terminal 5 always high
	task automatic tmode(input logic [2:0] s, input logic [3:0] er, input logic [3:0] ed);
		logic [10:0] pat [4];
		pat = '{11'h028, 11'h428, 11'h420, 11'h020};
		cfg(s, 14'd0, 8'd7, 3'h3, 1'b0);
		for (int k = 0; k < 4; k++) begin
			far.set_lv(pat[k], 3'h0, 2'h0, 2'h0);
			wait_run(er[k], ed[k]);
		end
	endtask : tmode

	task automatic stop_test;
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(25 * 6000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		{we, fwe, sel, dly, st, rate, fidx, fcode, proto, fmt} = '0;
		i_rst_n = 1'b0;
		tick(5);
		i_rst_n = 1'b1;
		tick(3);
		chk("selector", SRC_TWO_WIRE, o_sel);
		chk("station", 14'd1, o_st);
		chk("protocol", 14'd0, o_proto);
		chk("rate", 14'd3, o_rate);
		chk("format", 14'd0, o_fmt);
		cfg(SRC_SERIAL, 14'd100, 8'd0, 3'h3, 1'b1);
		cfg(SRC_SERIAL, 14'd100, 8'd251, 3'h3, 1'b1);
		cfg(SRC_SERIAL, 14'd100, 8'd1, 3'h6, 1'b1);
		cfg(SRC_SERIAL, 14'd10001, 8'd1, 3'h3, 1'b1);
		chk("selector", SRC_TWO_WIRE, o_sel);
		for (int r = 0; r < 6; r++) begin
			proto = r[1:0];
			fmt = r[1:0];
			cfg(SRC_SERIAL, 14'd10000, 8'd250, r[2:0], 1'b0);
			chk("rate", r, o_rate);
			chk("protocol", r[1:0], o_proto);
			chk("format", r[1:0], o_fmt);
			chk("station", 14'h00fa, o_st);
		end
		fw(4'd11, FUNC_FWD_RUN, 1'b1);
		fw(4'd0, 6'd52, 1'b1);
		fw(4'd5, FUNC_MAX, 1'b0);
		fw(4'd5, 6'd0, 1'b0);
		fw(4'd3, FUNC_FWD_RUN, 1'b0);
		fw(4'd10, FUNC_REV_DIR, 1'b0);
		tmode(SRC_TWO_WIRE, 4'b0101, 4'b0100);
		tmode(SRC_RUN_DIR, 4'b0011, 4'b0010);
		// Run-on delay of 0.01 s holds the start well past 40 cycles
		cfg(SRC_TWO_WIRE, 14'h0001, 8'h07, 3'h3, 1'b0);
		far.set_lv(11'h028, 3'h0, 2'h0, 2'h0);
		tick(3);
		chk("pending", 14'h0001, pend);
		tick(40);
		chk("run", 14'h0000, run);
		far.set_lv(11'h020, 3'h0, 2'h0, 2'h0);
		tick(3);
		chk("pending", 14'h0000, pend);
		// Keypad, with terminal and fieldbus requests that must be ignored
		cfg(SRC_KEYPAD, 14'h0000, 8'h07, 3'h3, 1'b0);
		far.set_lv(11'h028, 3'h0, 2'h2, 2'h2);
		tick(6);
		chk("run", 14'h0000, run);
		far.set_lv(11'h000, 3'h1, 2'h0, 2'h0);
		tick(1);
		far.set_lv(11'h000, 3'h0, 2'h0, 2'h0);
		wait_run(1'b1, 1'b0);
		far.set_lv(11'h000, 3'h4, 2'h0, 2'h0);
		wait_run(1'b0, 1'b0);
		far.set_lv(11'h000, 3'h2, 2'h0, 2'h0);
		tick(1);
		far.set_lv(11'h000, 3'h0, 2'h0, 2'h0);
		wait_run(1'b1, 1'b1);
		far.set_lv(11'h000, 3'h4, 2'h0, 2'h0);
		wait_run(1'b0, 1'b0);
		far.set_lv(11'h000, 3'h0, 2'h0, 2'h0);
		// Serial host: a frame for another station changes nothing
		cfg(SRC_SERIAL, 14'h0000, 8'h07, 3'h3, 1'b0);
		far.send_frame(8'h06, 1'b1, 1'b0);
		chk("addr_match", 14'h0000, match);
		tick(6);
		chk("run", 14'h0000, run);
		far.send_frame(8'h07, 1'b1, 1'b1);
		chk("addr_match", 14'h0001, match);
		wait_run(1'b1, 1'b1);
		far.send_frame(8'h07, 1'b0, 1'b0);
		wait_run(1'b0, 1'b0);
		// Fieldbus then PLC, each blind to the other
		cfg(SRC_FIELDBUS, 14'h0000, 8'h07, 3'h3, 1'b0);
		far.set_lv(11'h000, 3'h0, 2'h3, 2'h0);
		wait_run(1'b1, 1'b1);
		far.set_lv(11'h000, 3'h0, 2'h0, 2'h2);
		wait_run(1'b0, 1'b0);
		cfg(SRC_PLC, 14'h0000, 8'h07, 3'h3, 1'b0);
		wait_run(1'b1, 1'b0);
		far.set_lv(11'h000, 3'h0, 2'h2, 2'h0);
		wait_run(1'b0, 1'b0);
		stop_test();
	end
endmodule : test_run_command_source_select
